// *** verilog/dvs_ctrl.sv ***
/*
 * Voltage-scaling control: two-wire serial register slave, floor and roof
 * level registers, strategy selection, ramp sequencing and power-good flag.
 * Assumes all pins are asynchronous to CLOCK and that SCL is far slower
 * than CLOCK, so edges are found by oversampling.
 */
module dvs_ctrl
   import dvs_pkg::*;
#(
   parameter logic [1:0] BUS_ADDR_LSBS = 2'h0,
   parameter logic       COARSE_STEP   = 1'h0
) (
   input  wire logic        CLOCK,
   input  wire logic        NRST,
   input  wire logic        SCL,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE_N,
   input  wire logic        LEVEL_SELECT_PIN,
   input  wire logic        ENABLE_PIN,
   input  wire logic        PFM_PULSING,
   input  wire logic        OUTPUT_BELOW_TARGET,
   output logic [5:0]       TARGET_CODE,
   output logic [21:0]      TARGET_LEVEL_UV,
   output logic [1:0]       ACTIVE_MODE,
   output logic             FAST_SLEW,
   output logic             RAMPING,
   output logic             OUTPUT_GOOD,
   output logic             CONVERTER_RUN,
   output logic             INDUCTOR_TUNING
);
   import dvs_pkg::*;

   typedef enum {ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA} bus_state_e;

   logic [5:0] pins_sync;
   logic       scl_s, sda_s, level_s, enable_s, pulsing_s, below_s;
   logic       scl_prev_reg, sda_prev_reg;
   logic       scl_rise, scl_fall, start_seen, stop_seen;
   bus_state_e state_reg;
   logic [3:0] bit_cnt_reg;
   logic       ack_phase_reg, master_nack_reg;
   logic [7:0] shift_reg, tx_reg, ptr_reg;
   logic       wr_pulse;
   logic [7:0] wr_addr, wr_data;
   logic [5:0] floor_code_reg, roof_code_reg;
   logic       enable_bit_reg;
   logic [7:0] mode_reg;
   logic [2:0] slew_reg;
   logic       strategy_reg, start_reg;
   logic [7:0] rd_value;
   logic [5:0] goal_code;
   logic [1:0] goal_mode;
   logic       done_sw;
   logic [11:0] tick_cnt_reg;
   logic       discharge_reg;
   logic [21:0] step_uv;

   // ----------------------------------------------------------------------
   // Pin synchronisation and bus edge detection
   // ----------------------------------------------------------------------
   dvs_sync #(.WIDTH(6)) u_sync (
      .clk      (CLOCK),
      .rst_n    (NRST),
      .async_in ({SCL, SDA_IN, LEVEL_SELECT_PIN, ENABLE_PIN, PFM_PULSING, OUTPUT_BELOW_TARGET}),
      .sync_out (pins_sync)
   );
   assign {scl_s, sda_s, level_s, enable_s, pulsing_s, below_s} = pins_sync;

   // Idle bus lines are high, so the history starts high.
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         scl_prev_reg <= 1'h1;
         sda_prev_reg <= 1'h1;
      end
      else
      begin
         scl_prev_reg <= scl_s;
         sda_prev_reg <= sda_s;
      end
   end

   assign scl_rise   = scl_s & ~scl_prev_reg;
   assign scl_fall   = ~scl_s & scl_prev_reg;
   assign start_seen = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
   assign stop_seen  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

   // ----------------------------------------------------------------------
   // Serial slave: address, register pointer, write and read bytes
   // ----------------------------------------------------------------------
   // The pointer advances after each data byte so bursts walk the register map.
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         state_reg       <= ST_IDLE;
         bit_cnt_reg     <= 4'h0;
         ack_phase_reg   <= 1'h0;
         master_nack_reg <= 1'h0;
         shift_reg       <= 8'h00;
         tx_reg          <= 8'hff;
         ptr_reg         <= 8'h00;
         SDA_OE_N        <= 1'h1;
      end
      else if (start_seen)
      begin
         state_reg     <= ST_ADDR;
         bit_cnt_reg   <= 4'h0;
         ack_phase_reg <= 1'h0;
         SDA_OE_N      <= 1'h1;
      end
      else if (stop_seen)
      begin
         state_reg     <= ST_IDLE;
         ack_phase_reg <= 1'h0;
         SDA_OE_N      <= 1'h1;
      end
      else if (scl_rise && state_reg != ST_IDLE)
      begin
         if (ack_phase_reg)
            master_nack_reg <= sda_s;
         else
         begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
      end
      else if (scl_fall && state_reg != ST_IDLE)
      begin
         if (ack_phase_reg)
         begin
            ack_phase_reg <= 1'h0;
            bit_cnt_reg   <= 4'h0;
            if (state_reg == ST_RDATA && !master_nack_reg)
            begin
               tx_reg   <= rd_value;
               SDA_OE_N <= rd_value[7];
            end
            else if (state_reg == ST_RDATA)
            begin
               state_reg <= ST_IDLE;
               SDA_OE_N  <= 1'h1;
            end
            else
               SDA_OE_N <= 1'h1;
         end
         else if (state_reg == ST_RDATA)
         begin
            if (bit_cnt_reg == 4'h8)
            begin
               ack_phase_reg   <= 1'h1;
               master_nack_reg <= 1'h0;
               ptr_reg         <= ptr_reg + 8'h01;
               SDA_OE_N        <= 1'h1;
            end
            else
            begin
               tx_reg   <= {tx_reg[6:0], 1'h1};
               SDA_OE_N <= tx_reg[6];
            end
         end
         else if (bit_cnt_reg == 4'h8)
         begin
            case (state_reg)
               ST_ADDR:
               begin
                  if (shift_reg[7:1] == {BUS_ADDR_MSBS, BUS_ADDR_LSBS})
                  begin
                     ack_phase_reg   <= 1'h1;
                     master_nack_reg <= 1'h0;
                     SDA_OE_N        <= 1'h0;
                     state_reg       <= shift_reg[0] ? ST_RDATA : ST_REG;
                  end
                  else
                     state_reg <= ST_IDLE;
               end
               ST_REG:
               begin
                  ptr_reg       <= shift_reg;
                  ack_phase_reg <= 1'h1;
                  SDA_OE_N      <= 1'h0;
                  state_reg     <= ST_WDATA;
               end
               ST_WDATA:
               begin
                  ptr_reg       <= ptr_reg + 8'h01;
                  ack_phase_reg <= 1'h1;
                  SDA_OE_N      <= 1'h0;
               end
               default:
                  state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // The write lands on the SCL fall that ends the data LSB.
   // A held-low enable pin means hardware shutdown, which blocks updates.
   assign wr_pulse = scl_fall & ~ack_phase_reg & (state_reg == ST_WDATA) & (bit_cnt_reg == 4'h8) & enable_s;
   assign wr_addr  = ptr_reg;
   assign wr_data  = shift_reg;

   // Read mux; shared bits appear in both level registers.
   always_comb
   begin
      case (ptr_reg)
         ADDR_FLOOR: rd_value = {enable_bit_reg, INDUCTOR_TUNING, floor_code_reg};
         ADDR_ROOF:  rd_value = {enable_bit_reg, INDUCTOR_TUNING, roof_code_reg};
         ADDR_MODE:  rd_value = mode_reg;
         ADDR_RAMP:  rd_value = {start_reg, 1'h0, strategy_reg, 2'h0, slew_reg};
         default:    rd_value = READ_UNMAPPED;
      endcase
   end

   // The pin is open drain: the line is only ever pulled low.
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
         SDA_OUT <= 1'h0;
      else
         SDA_OUT <= 1'h0;
   end

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   // Step codes fill the low six bits; all 64 values are legal.
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         floor_code_reg  <= FLOOR_CODE_RST;
         roof_code_reg   <= ROOF_CODE_RST;
         INDUCTOR_TUNING <= TUNE_RST;
         enable_bit_reg  <= ENABLE_RST;
         mode_reg        <= MODE_RST;
         slew_reg        <= SLEW_RST;
         strategy_reg    <= STRATEGY_RST;
      end
      else if (wr_pulse)
      begin
         case (wr_addr)
            ADDR_FLOOR, ADDR_ROOF:
            begin
               if (wr_addr == ADDR_FLOOR)
                  floor_code_reg <= wr_data[CODE_MSB:0];
               else
                  roof_code_reg <= wr_data[CODE_MSB:0];
               INDUCTOR_TUNING <= wr_data[TUNE_BIT];
               enable_bit_reg  <= wr_data[ENABLE_BIT];
            end
            ADDR_MODE:
               mode_reg <= wr_data;
            ADDR_RAMP:
            begin
               slew_reg     <= wr_data[SLEW_LSB+2:SLEW_LSB];
               strategy_reg <= wr_data[STRATEGY_BIT];
            end
            default:
               mode_reg <= mode_reg;
         endcase
      end
   end

   // Start bit: a host set beats the self-clear in the same cycle.
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
         start_reg <= 1'h0;
      else if (wr_pulse && wr_addr == ADDR_RAMP && wr_data[START_BIT] && !wr_data[STRATEGY_BIT])
         start_reg <= 1'h1;
      else if (strategy_reg || done_sw)
         start_reg <= 1'h0;
   end

   // ----------------------------------------------------------------------
   // Target selection
   // ----------------------------------------------------------------------
   // Hardware strategy tracks the pin live, so an unselected write never
   // alters the goal while a selected write moves it at once.
   always_comb
   begin
      if (strategy_reg)
      begin
         goal_code = level_s ? roof_code_reg : floor_code_reg;
         goal_mode = level_s ? mode_reg[ROOF_MODE_LSB +: 2] : mode_reg[FLOOR_MODE_LSB +: 2];
      end
      else if (start_reg)
      begin
         goal_code = roof_code_reg;
         goal_mode = mode_reg[ROOF_MODE_LSB +: 2];
      end
      else
      begin
         goal_code = TARGET_CODE;
         goal_mode = ACTIVE_MODE;
      end
   end

   assign done_sw = ~strategy_reg & start_reg & (TARGET_CODE == roof_code_reg);

   // ----------------------------------------------------------------------
   // Ramp sequencer
   // ----------------------------------------------------------------------
   // Single-step jumps straight to the goal; the analog loop then slews at
   // full rate upward, or simply lets the load pull a pulse-frequency rail
   // down. Multiple-step moves one code per lookup interval.
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         TARGET_CODE  <= FLOOR_CODE_RST;
         ACTIVE_MODE  <= MODE_RST[1:0];
         FAST_SLEW    <= 1'h0;
         RAMPING      <= 1'h0;
         tick_cnt_reg <= 12'h000;
      end
      else
      begin
         ACTIVE_MODE <= goal_mode;
         if (slew_reg == SLEW_SINGLE)
         begin
            FAST_SLEW    <= goal_code > TARGET_CODE;
            TARGET_CODE  <= goal_code;
            RAMPING      <= 1'h0;
            tick_cnt_reg <= 12'h000;
         end
         else if (goal_code != TARGET_CODE)
         begin
            FAST_SLEW <= 1'h0;
            RAMPING   <= 1'h1;
            if (tick_cnt_reg >= step_cycles(slew_reg) - 12'h001)
            begin
               tick_cnt_reg <= 12'h000;
               TARGET_CODE  <= (goal_code > TARGET_CODE) ? TARGET_CODE + 6'h01 : TARGET_CODE - 6'h01;
            end
            else
               tick_cnt_reg <= tick_cnt_reg + 12'h001;
         end
         else
         begin
            FAST_SLEW    <= 1'h0;
            RAMPING      <= 1'h0;
            tick_cnt_reg <= 12'h000;
         end
      end
   end

   // Level reported for the reference; the coarse variant doubles the step.
   assign step_uv = COARSE_STEP ? 22'(STEP_COARSE_UV) : 22'(STEP_FINE_UV);

   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
         TARGET_LEVEL_UV <= 22'(MIN_LEVEL_UV);
      else
         TARGET_LEVEL_UV <= 22'(MIN_LEVEL_UV) + 22'(TARGET_CODE) * step_uv;
   end

   // ----------------------------------------------------------------------
   // Power-good and enable
   // ----------------------------------------------------------------------
   // A downward move into a pulse-frequency mode holds the flag low until
   // the converter pulses again; a new discharge start beats the release.
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
         discharge_reg <= 1'h0;
      else if (goal_code < TARGET_CODE && goal_mode != MODE_FORCED_PWM)
         discharge_reg <= 1'h1;
      else if (pulsing_s)
         discharge_reg <= 1'h0;
   end

   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
         OUTPUT_GOOD <= 1'h0;
      else if (slew_reg != SLEW_SINGLE && goal_code != TARGET_CODE)
         OUTPUT_GOOD <= 1'h0;
      // The flag also drops in the very cycle a discharge move is issued.
      else if (discharge_reg || (goal_code < TARGET_CODE && goal_mode != MODE_FORCED_PWM))
         OUTPUT_GOOD <= 1'h0;
      else
         OUTPUT_GOOD <= ~below_s;
   end

   // Shutdown wins whenever the shared bit is clear.
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
         CONVERTER_RUN <= 1'h0;
      else
         CONVERTER_RUN <= enable_bit_reg & enable_s;
   end

endmodule

// *** verilog/dvs_pkg.sv ***
/*
 * Shared constants for the voltage-scaling control block: register
 * offsets, field positions, reset values, mode encodings and ramp timing.
 * Assumes a 50 MHz core clock and a two-wire serial host that owns SCL.
 */
//
// Behaviour
// - Strategy bit 1 picks pin-driven hardware scaling, 0 picks software scaling.
// - Hardware strategy: pin low targets floor code, pin high targets roof code.
// - Hardware strategy: writing the selected register moves output immediately at ramp rate.
// - Hardware strategy: writing the unselected register leaves the output unchanged.
// - Software strategy: target comes only from roof; pin and floor ignored.
// - Software strategy: change starts on start bit; bit self-clears at target.
// - Start bit acts only in software strategy; writing 1 starts a ramp.
// - Multiple-step mode: output good is low for the whole ramp.
// - Otherwise output good is low when output is over 1.5 percent low.
// - Pulse-frequency downward move: output good low until converter resumes pulsing.
// - Slew code 111 is single-step (default); 000 to 110 are multiple-step.
// - Single-step upward move goes at maximum slew with no stepping.
// - Single-step downward: immediate for forced pulse-width, uncontrolled fall for pulse-frequency.
// - Multiple-step mode paces micro-steps both directions in every strategy and mode.
// - Floor and roof step codes are six-bit linear codes, 0 to 63 valid.
// - Level equals minimum level plus code times 12.5 mV, or 25 mV coarse.
// - Bit 6 tunes light pulse-frequency: 0 for 2.2 uH, 1 for 1 uH (reset).
// - Bit 7 gates the enable pin: 0 forces shutdown, 1 follows the pin.
// - Bits 6 and 7 are shared storage between floor and roof registers.
// - A serial register write takes effect on SCL fall of the data LSB.
// - Reading any unimplemented register address returns FFh.
package dvs_pkg;

   // ----------------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_FLOOR     = 8'h00;
   localparam logic [7:0] ADDR_ROOF      = 8'h01;
   localparam logic [7:0] ADDR_MODE      = 8'h02;
   localparam logic [7:0] ADDR_RAMP      = 8'h03;
   localparam logic [7:0] READ_UNMAPPED  = 8'hff;
   localparam int         CODE_MSB       = 5;
   localparam int         TUNE_BIT       = 6;
   localparam int         ENABLE_BIT     = 7;
   localparam int         SLEW_LSB       = 0;
   localparam int         STRATEGY_BIT   = 5;
   localparam int         START_BIT      = 7;
   localparam int         FLOOR_MODE_LSB = 0;
   localparam int         ROOF_MODE_LSB  = 2;

   // ----------------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------------
   localparam logic [5:0] FLOOR_CODE_RST  = 6'h00;
   localparam logic [5:0] ROOF_CODE_RST   = 6'h00;
   localparam logic       TUNE_RST        = 1'h1;
   localparam logic       ENABLE_RST      = 1'h1;
   localparam logic [7:0] MODE_RST        = 8'h00;
   localparam logic [2:0] SLEW_RST        = 3'h7;
   localparam logic       STRATEGY_RST    = 1'h1;
   localparam logic [2:0] SLEW_SINGLE     = 3'h7;
   localparam logic [1:0] MODE_LIGHT_PFM  = 2'h0;
   localparam logic [1:0] MODE_FAST_PFM   = 2'h1;
   localparam logic [1:0] MODE_FORCED_PWM = 2'h2;
   localparam logic [4:0] BUS_ADDR_MSBS   = 5'h12;

   // ----------------------------------------------------------------------
   // Output level arithmetic and ramp timing
   // ----------------------------------------------------------------------
   localparam int unsigned STEP_FINE_UV   = 12500;
   localparam int unsigned STEP_COARSE_UV = 25000;
   localparam int unsigned MIN_LEVEL_UV   = 600000;
   localparam int unsigned CLK_NS         = 20;
   localparam int unsigned STEP_NS [0:6]  = '{32000, 16000, 8000, 4000, 2000, 1000, 500};

   // Least interval, so cycles round up.
   function automatic logic [11:0] step_cycles(input logic [2:0] code);
      int unsigned idx;
      idx = (code == SLEW_SINGLE) ? 0 : int'(code);
      return 12'((STEP_NS[idx] + CLK_NS - 1) / CLK_NS);
   endfunction

endpackage

// *** verilog/dvs_sync.sv ***
/*
 * Two-stage synchroniser for a bundle of asynchronous level inputs.
 * Assumes each bit is a slow level; no multi-bit coherence is implied.
 */
module dvs_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // The first stage feeds only the second, so metastability stays contained.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// *** verification/serial_host.sv ***
/*
 * Two-wire serial bus master model that reaches the control registers.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
module serial_host
   import dvs_pkg::*;
(
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Both lines are released, so the clock stands still high between frames.
   initial
   begin
      scl = 1'b1;
      sda_o = 1'b1;
   end

   // A quarter of the 160 ns serial period; moves land on falling core edges.
   task automatic q;
      repeat (2) @(negedge clk);
   endtask

   // Data changes only while the clock is low and is sampled mid-high.
   task automatic bit_io(input logic b, output logic r);
      sda_o = b;
      q();
      scl = 1'b1;
      q();
      r = sda;
      q();
      scl = 1'b0;
      q();
   endtask

   task automatic start;
      sda_o = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_o = 1'b0;
      q();
      scl = 1'b0;
      q();
   endtask

   task automatic stop;
      sda_o = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_o = 1'b1;
      q();
   endtask

   // One byte MSB first, then the acknowledge bit in the other direction.
   task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r[i]);
      bit_io(m, a);
   endtask

   // A missing acknowledge anywhere in the frame sets nak.
   task automatic write_reg(input logic [7:0] p, input logic [7:0] v, output logic nak);
      logic [7:0] r;
      logic       a0, a1, a2;
      start();
      xfer({BUS_ADDR_MSBS, 2'h0, 1'b0}, 1'b1, r, a0);
      xfer(p, 1'b1, r, a1);
      xfer(v, 1'b1, r, a2);
      stop();
      nak = a0 | a1 | a2;
   endtask

   // The final not-acknowledge tells the device that one byte is enough.
   task automatic read_reg(input logic [7:0] p, output logic [7:0] v, output logic nak);
      logic [7:0] r;
      logic       a0, a1, a2, a3;
      start();
      xfer({BUS_ADDR_MSBS, 2'h0, 1'b0}, 1'b1, r, a0);
      xfer(p, 1'b1, r, a1);
      start();
      xfer({BUS_ADDR_MSBS, 2'h0, 1'b1}, 1'b1, r, a2);
      xfer(8'hff, 1'b1, v, a3);
      stop();
      nak = a0 | a1 | a2;
   endtask
endmodule

// *** verification/dvs_ctrl_properties.sv ***
/*
 * Port checker for the voltage-scaling control block.
 * Assumes one clock domain and the active-low asynchronous reset.
 */
module dvs_ctrl_properties
   import dvs_pkg::*;
#(
   parameter logic COARSE_STEP = 1'h0
) (
   input wire logic        CLOCK,
   input wire logic        NRST,
   input wire logic        SDA_OE_N,
   input wire logic        ENABLE_PIN,
   input wire logic        OUTPUT_BELOW_TARGET,
   input wire logic [5:0]  TARGET_CODE,
   input wire logic [21:0] TARGET_LEVEL_UV,
   input wire logic        FAST_SLEW,
   input wire logic        RAMPING,
   input wire logic        OUTPUT_GOOD,
   input wire logic        CONVERTER_RUN
);
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (!NRST);

   // Four cycles cover the two sync flops plus the output register.
   sequence pin_held_low;
      !ENABLE_PIN [*4];
   endsequence

   sequence below_held;
      OUTPUT_BELOW_TARGET [*4];
   endsequence

   ramp_good_low_a:
   assert property (RAMPING && $past(RAMPING) |-> !OUTPUT_GOOD) else $error("good high during ramp");
   below_good_low_a:
   assert property (below_held |-> !OUTPUT_GOOD) else $error("good high while output low");
   ramp_one_step_a:
   assert property (RAMPING && $changed(TARGET_CODE) |-> TARGET_CODE == $past(TARGET_CODE) + 6'h1
      || TARGET_CODE == $past(TARGET_CODE) - 6'h1) else $error("ramp moved more than one step");
   ramp_step_gap_a:
   assert property (RAMPING && $changed(TARGET_CODE) |=> $stable(TARGET_CODE) [*8]) else $error("steps too close");
   level_from_code_a:
   assert property (TARGET_LEVEL_UV == 22'(MIN_LEVEL_UV + $past(TARGET_CODE)
      * (COARSE_STEP ? STEP_COARSE_UV : STEP_FINE_UV))) else $error("level does not match code");
   fast_jump_up_a:
   assert property (FAST_SLEW |-> TARGET_CODE > $past(TARGET_CODE) && !RAMPING) else $error("bad fast jump");
   enable_gate_a:
   assert property (pin_held_low |-> !CONVERTER_RUN) else $error("runs with enable pin low");
   jump_is_fast_a:
   assert property (!RAMPING && TARGET_CODE > $past(TARGET_CODE) |-> FAST_SLEW) else $error("slow upward jump");
   ack_stands_a:
   assert property ($fell(SDA_OE_N) |=> !SDA_OE_N [*6]) else $error("data drive released early");
endmodule

// *** verification/tb_dvs_ctrl.sv ***
/*
 * Self-checking bench for the voltage-scaling control block.
 * Assumes the serial host model and the port checker bound below.
 */
module tb_dvs_ctrl;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clock, nrst, scl, sda_m, sel, en, pulsing, below, nak;
   logic        sda_out, sda_oe_n, fast, ramping, good, run, tune;
   logic [5:0]  code;
   logic [21:0] level;
   logic [1:0]  mode;
   logic [7:0]  v;
   wire logic   sda = sda_m & (sda_oe_n | sda_out);
   int          n_fail, tests_run, n;

   dvs_ctrl u_dvs_ctrl (.CLOCK(clock), .NRST(nrst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
      .SDA_OE_N(sda_oe_n), .LEVEL_SELECT_PIN(sel), .ENABLE_PIN(en), .PFM_PULSING(pulsing),
      .OUTPUT_BELOW_TARGET(below), .TARGET_CODE(code), .TARGET_LEVEL_UV(level), .ACTIVE_MODE(mode),
      .FAST_SLEW(fast), .RAMPING(ramping), .OUTPUT_GOOD(good), .CONVERTER_RUN(run), .INDUCTOR_TUNING(tune));
   serial_host u_serial_host (.clk(clock), .sda(sda), .scl(scl), .sda_o(sda_m));

   // 50 MHz core clock.
   always #10 clock = ~clock;

   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask

   task automatic wt(input int c);
      repeat (c) @(negedge clock);
   endtask

   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      u_serial_host.write_reg(p, d, nak);
      chk(nak === 1'b0, "write refused");
      wt(4);
   endtask

   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      u_serial_host.read_reg(p, v, nak);
      chk(nak === 1'b0 && v === e, "read value");
   endtask

   // Ramp length is counted so the pacing can be judged, bounded against a hang.
   task automatic ramp_wait;
      n = 0;
      while (ramping !== 1'b0 && n < 400)
      begin
         wt(1);
         n++;
      end
   endtask

   task automatic t_reset;
      chk(tune === 1'b1 && run === 1'b1 && code === 6'h0, "reset outputs");
      rd(8'h00, 8'hc0);
   endtask

   task automatic t_shared;
      wr(8'h00, 8'h05);
      chk(run === 1'b0 && tune === 1'b0 && code === 6'h05, "floor write");
      rd(8'h01, 8'h00);
      wr(8'h00, 8'hc5);
      rd(8'h01, 8'hc0);
      chk(run === 1'b1, "enable bit set");
      en = 1'b0;
      wt(8);
      chk(run === 1'b0, "pin low shuts down");
      en = 1'b1;
      wt(8);
   endtask

   task automatic t_hw;
      wr(8'h01, 8'hca);
      chk(code === 6'h05, "unselected roof write");
      wr(8'h00, 8'hcc);
      chk(code === 6'h0c, "selected floor write");
      pulsing = 1'b0;
      sel = 1'b1;
      wt(10);
      chk(code === 6'h0a && good === 1'b0, "discharge to roof");
      pulsing = 1'b1;
      wt(10);
      chk(good === 1'b1, "pulsing again");
      wr(8'h00, 8'hcf);
      chk(code === 6'h0a, "unselected floor write");
   endtask

   task automatic t_low;
      below = 1'b1;
      wt(8);
      chk(good === 1'b0, "output below target");
      below = 1'b0;
      wt(8);
      chk(good === 1'b1, "output in range");
      wr(8'h02, 8'h08);
      sel = 1'b0;
      wt(10);
      chk(code === 6'h0f && mode === 2'h0, "single step up");
      pulsing = 1'b0;
      sel = 1'b1;
      wt(10);
      chk(code === 6'h0a && good === 1'b1 && mode === 2'h2, "forced pwm drop");
      pulsing = 1'b1;
      rd(8'h05, 8'hff);
   endtask

   task automatic t_multi;
      wr(8'h03, 8'h26);
      sel = 1'b0;
      wt(6);
      chk(ramping === 1'b1 && good === 1'b0 && code !== 6'h0f, "ramp up");
      ramp_wait();
      chk(code === 6'h0f && n >= 90, "ramp up pacing");
      sel = 1'b1;
      wt(6);
      chk(ramping === 1'b1, "ramp down");
      ramp_wait();
      chk(code === 6'h0a && n >= 90, "ramp down pacing");
   endtask

   task automatic t_sw;
      wr(8'h03, 8'h07);
      wr(8'h01, 8'he0);
      chk(code === 6'h0a, "no start yet");
      sel = 1'b0;
      wt(8);
      chk(code === 6'h0a, "pin ignored");
      wr(8'h03, 8'h87);
      chk(code === 6'h20, "start moves");
      rd(8'h03, 8'h07);
      wr(8'h00, 8'hc1);
      chk(code === 6'h20, "floor ignored");
   endtask

   task automatic summarize;
      $display("n_fail=%0d tests_run=%0d", n_fail, tests_run);
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence: 16 cycles of reset, then the scenarios in order.
   initial
   begin
      clock = 1'b0;
      nrst = 1'b0;
      sel = 1'b0;
      en = 1'b1;
      pulsing = 1'b1;
      below = 1'b0;
      wt(16);
      nrst = 1'b1;
      wt(8);
      t_reset();
      t_shared();
      t_hw();
      t_low();
      t_multi();
      t_sw();
      summarize();
   end

   // The scenarios need about 4500 cycles, so this limit only trips on a hang.
   initial
   begin
      repeat (40000) @(posedge clock);
      n_fail++;
      $display("mismatch %0t timeout", $time);
      summarize();
   end
endmodule

bind dvs_ctrl dvs_ctrl_properties #(.COARSE_STEP(COARSE_STEP)) u_dvs_ctrl_properties (.CLOCK(CLOCK),
   .NRST(NRST), .SDA_OE_N(SDA_OE_N), .ENABLE_PIN(ENABLE_PIN),
   .OUTPUT_BELOW_TARGET(OUTPUT_BELOW_TARGET), .TARGET_CODE(TARGET_CODE), .TARGET_LEVEL_UV(TARGET_LEVEL_UV),
   .FAST_SLEW(FAST_SLEW), .RAMPING(RAMPING), .OUTPUT_GOOD(OUTPUT_GOOD), .CONVERTER_RUN(CONVERTER_RUN));
